// ==== rtl/serial_status_pkg.sv ====
package serial_status_pkg;

	// ==========================================================
	// Register map, byte addresses on the Avalon slave.
	localparam logic [4:0] STATUS_OFS = 5'h00;
	localparam logic [4:0] CARD_OFS   = 5'h04;
	localparam logic [4:0] CTRL_OFS   = 5'h08;
	localparam logic [4:0] TXH_OFS    = 5'h0c;
	localparam logic [4:0] RXH_OFS    = 5'h10;

	// ==========================================================
	// Status register fields.
	localparam int ST_TRANSMIT_EMPTY_FLAG = 7;
	localparam int ST_RECEIVE_FULL_FLAG = 6;
	localparam int ST_OVERRUN_FAULT_FLAG = 5;
	localparam int ST_FER  = 4;
	localparam int ST_PER  = 3;
	localparam int ST_TRANSMIT_DONE_FLAG = 2;
	localparam int ST_MPB  = 1;
	localparam int ST_MULTIPROC_TX_BIT = 0;
	localparam logic [7:0] ST_RESET = 8'h84;

	// ==========================================================
	// Card mode register fields.
	localparam int CM_CLOCK_COUNT_TOP_BIT = 7;
	localparam int CM_BIT_ORDER_SELECT = 3;
	localparam int CM_DATA_INVERT_SELECT = 2;
	localparam int CM_CARD_MODE_SELECT = 0;
	localparam logic [7:0] CM_WRITABLE = 8'h8d;
	localparam logic [7:0] CM_ONES     = 8'h72;
	localparam logic [7:0] CM_RESET    = 8'hf2;

	// ==========================================================
	// Control register fields.
	localparam int CT_TE    = 0;
	localparam int CT_RE    = 1;
	localparam int CT_GM    = 2;
	localparam int CT_BLK   = 3;
	localparam int CT_CLOCK_COUNT_LOW_BIT  = 4;
	localparam int CT_CLOCK_COUNT_MID_BIT  = 5;
	localparam int CT_SYNC  = 6;
	localparam int CT_SEVEN = 7;
	localparam logic [7:0] CT_RESET = 8'h00;

	// ==========================================================
	// Transmit-done delay in half bit-time units.
	localparam logic [2:0] HALF_ETU_BLK0 = 3'h5;
	localparam logic [2:0] HALF_ETU_BLK1 = 3'h3;
	localparam logic [2:0] HALF_ETU_GM1  = 3'h2;

	typedef struct packed {
		logic [4:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} avs_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic       stop_bit;
		logic       parity_ok;
		logic       mp_bit;
	} rx_frame_t;

endpackage

// ==== rtl/bit_order_invert.sv ====
`timescale 1ns/1ps
`default_nettype none
module bit_order_invert
(
	input  wire logic [7:0] data_i,
	input  wire logic       seven_bit_i,
	input  wire logic       msb_first_i,
	input  wire logic       invert_i,
	output logic      [7:0] data_o
);
	logic [7:0] inv;
	logic [7:0] rev;

	// The parity bit never passes here, so inversion cannot reach it.
	always_comb
	begin
		inv = invert_i ? ~data_i : data_i;
		if (seven_bit_i)
			inv[7] = data_i[7];
		for (int i = 0; i < 8; i++)
			rev[i] = inv[7 - i];
		data_o = (msb_first_i && !seven_bit_i) ? rev : inv;
	end
endmodule
`default_nettype wire

// ==== rtl/card_done_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module card_done_timer
	import serial_status_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	input  wire logic start_i,
	input  wire logic half_etu_i,
	input  wire logic gm_i,
	input  wire logic blk_i,
	output logic      fire_o
);
	typedef struct packed {
		logic       busy;
		logic [2:0] cnt;
		logic       fire;
	} tmr_t;

	tmr_t       tmr_ff;
	tmr_t       nxt_tmr;
	logic [2:0] target;

	always_comb
	begin
		target = gm_i ? HALF_ETU_GM1 : (blk_i ? HALF_ETU_BLK1 : HALF_ETU_BLK0);
		nxt_tmr = tmr_ff;
		nxt_tmr.fire = 1'b0;
		if (start_i)
		begin
			nxt_tmr.busy = 1'b1;
			nxt_tmr.cnt = 3'h0;
		end
		else if (tmr_ff.busy && half_etu_i)
		begin
			nxt_tmr.cnt = tmr_ff.cnt + 3'h1;
			if (nxt_tmr.cnt == target)
			begin
				nxt_tmr.busy = 1'b0;
				nxt_tmr.fire = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			tmr_ff <= '0;
		else
			tmr_ff <= nxt_tmr;
	end

	assign fire_o = tmr_ff.fire;
endmodule
`default_nettype wire

// ==== rtl/serial_status_card.sv ====
// Behaviour
// - Stop bit sampled 0 sets framing fault.
// - Two stop bits: only first is checked.
// - Framing fault: store char, no full flag.
// - Synchronous mode: framing fault stops transmission.
// - Flags clear by write 0 after read 1.
// - Receive disable keeps fault flags unchanged.
// - Parity fault: set flag, store, no full.
// - Normal transmit-done set/clear conditions.
// - Capture received multiprocessor bit.
// - Append multiprocessor transmit bit to frames.
// - Card mode transmit-empty set conditions, init 1.
// - Full flag only on clean reception.
// - Overrun keeps old char and halts reception.
// - Low error signal sets error-signal flag.
// - Card transmit-done after 2.5/1.5/1.0 etu.
// - Three clock-count bits select cycles per bit.
// - Card reserved bits read 1, ignore writes.
// - Bit order select, 7-bit always LSB-first; applied here in card mode only.
// - Inversion touches data bits, never parity; applied here in card mode only.
// - Card mode select picks smart card mode.
// - Card fields writable only with TE=RE=0.
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module serial_status_card
	import serial_status_pkg::*;
(
	input  wire logic                         ref_clk_i,
	input  wire logic                         rstn_i,
	input  wire serial_status_pkg::avs_req_t  avs_i,
	output logic                       [31:0] avs_readdata_o,
	output logic                              avs_waitrequest_o,
	input  wire logic                         rx_valid_i,
	input  wire serial_status_pkg::rx_frame_t rx_frame_i,
	input  wire logic                         tx_take_i,
	input  wire logic                         tx_last_bit_i,
	input  wire logic                         half_etu_i,
	input  wire logic                         err_line_i,
	input  wire logic                         err_sample_i,
	output logic                              tx_load_o,
	output logic                        [7:0] tx_data_o,
	output logic                              tx_mp_bit_o,
	output logic                              rx_halt_o,
	output logic                              tx_halt_o,
	output logic                        [2:0] clock_count_sel_o,
	output logic                              smart_card_o
);
	import serial_status_pkg::*;

	// ==========================================================
	// State.
	typedef struct packed {
		logic        waitreq;
		logic [31:0] rdata;
		logic        transmit_empty_flag;
		logic        receive_full_flag;
		logic        overrun_fault_flag;
		logic        framing_fault_flag;
		logic        error_signal_flag;
		logic        parity_fault_flag;
		logic        transmit_done_flag;
		logic        multiproc_rx_bit;
		logic        multiproc_tx_bit;
		logic [4:0]  arm;
		logic [7:0]  card;
		logic [7:0]  ctrl;
		logic [7:0]  txh;
		logic [7:0]  rxh;
		logic        tx_load;
		logic [7:0]  tx_data;
		logic        tx_mp;
		logic        err_s1;
		logic        err_s2;
		logic        rx_halt;
		logic        tx_halt;
	} state_t;

	// The error line idles high, so its synchroniser starts high as well.
	localparam state_t RST_STATE = '{waitreq: 1'b1, transmit_empty_flag: ST_RESET[ST_TRANSMIT_EMPTY_FLAG],
		transmit_done_flag: ST_RESET[ST_TRANSMIT_DONE_FLAG], card: CM_RESET, ctrl: CT_RESET,
		err_s1: 1'b1, err_s2: 1'b1, default: '0};

	state_t     state_ff;
	state_t     nxt_state;
	logic       req;
	logic       done;
	logic       wr;
	logic       st_wr;
	logic [4:0] clr;
	logic       te;
	logic       re;
	logic       card_mode_select;
	logic       halted;
	logic       rx_ok;
	logic       fire;
	logic [7:0] tx_fmt;
	logic [7:0] rx_fmt;

	function automatic logic [7:0] status_val(input state_t s);
		status_val = {s.transmit_empty_flag, s.receive_full_flag, s.overrun_fault_flag,
			s.card[CM_CARD_MODE_SELECT] ? s.error_signal_flag : s.framing_fault_flag, s.parity_fault_flag, s.transmit_done_flag, s.multiproc_rx_bit, s.multiproc_tx_bit};
	endfunction

	function automatic logic [31:0] read_word(input state_t s,
		input logic [4:0] a);
		read_word = 32'h0;
		if (a == STATUS_OFS)
			read_word[7:0] = status_val(s);
		else if (a == CARD_OFS)
			read_word[7:0] = s.card | CM_ONES;
		else if (a == CTRL_OFS)
			read_word[7:0] = s.ctrl;
		else if (a == TXH_OFS)
			read_word[7:0] = s.txh;
		else if (a == RXH_OFS)
			read_word[7:0] = s.rxh;
	endfunction

	// ==========================================================
	// Data formatting, shared by both directions.
	bit_order_invert u_tx_fmt
	(
		.data_i      (state_ff.txh),
		.seven_bit_i (state_ff.ctrl[CT_SEVEN]),
		.msb_first_i (card_mode_select && state_ff.card[CM_BIT_ORDER_SELECT]),
		.invert_i    (card_mode_select && state_ff.card[CM_DATA_INVERT_SELECT]),
		.data_o      (tx_fmt)
	);

	bit_order_invert u_rx_fmt
	(
		.data_i      (rx_frame_i.data),
		.seven_bit_i (state_ff.ctrl[CT_SEVEN]),
		.msb_first_i (card_mode_select && state_ff.card[CM_BIT_ORDER_SELECT]),
		.invert_i    (card_mode_select && state_ff.card[CM_DATA_INVERT_SELECT]),
		.data_o      (rx_fmt)
	);

	card_done_timer u_timer
	(
		.ref_clk_i  (ref_clk_i),
		.rstn_i     (rstn_i),
		.start_i    (state_ff.tx_load),
		.half_etu_i (half_etu_i),
		.gm_i       (state_ff.ctrl[CT_GM]),
		.blk_i      (state_ff.ctrl[CT_BLK]),
		.fire_o     (fire)
	);

	// ==========================================================
	// Next state.
	always_comb
	begin
		te = state_ff.ctrl[CT_TE];
		re = state_ff.ctrl[CT_RE];
		card_mode_select = state_ff.card[CM_CARD_MODE_SELECT];
		// Any fault halts reception; receive enable has no say here.
		halted = state_ff.overrun_fault_flag || state_ff.framing_fault_flag || state_ff.parity_fault_flag;
		rx_ok = rx_valid_i && re && !halted;
		req = avs_i.read || avs_i.write;
		done = req && !state_ff.waitreq;
		wr = done && avs_i.write && avs_i.byteenable[0];
		st_wr = wr && (avs_i.address == STATUS_OFS);
		nxt_state = state_ff;
		nxt_state.err_s1 = err_line_i;
		nxt_state.err_s2 = state_ff.err_s1;
		nxt_state.tx_load = 1'b0;

		// One wait state: the answer is registered, then released.
		if (req && state_ff.waitreq)
		begin
			nxt_state.waitreq = 1'b0;
			nxt_state.rdata = read_word(state_ff, avs_i.address);
		end
		else
			nxt_state.waitreq = 1'b1;

		if (done && avs_i.read && avs_i.address == STATUS_OFS)
			nxt_state.arm = state_ff.arm | state_ff.rdata[7:3];

		// Clears first; the hardware sets below win in the same cycle.
		clr = st_wr ? (~avs_i.writedata[7:3] & state_ff.arm) : 5'h0;
		if (st_wr)
		begin
			nxt_state.arm = 5'h0;
			nxt_state.multiproc_tx_bit = avs_i.writedata[ST_MULTIPROC_TX_BIT];
		end
		if (clr[4])
		begin
			nxt_state.transmit_empty_flag = 1'b0;
			nxt_state.transmit_done_flag = 1'b0;
		end
		if (clr[3])
			nxt_state.receive_full_flag = 1'b0;
		if (clr[2])
			nxt_state.overrun_fault_flag = 1'b0;
		if (clr[1] && card_mode_select)
			nxt_state.error_signal_flag = 1'b0;
		if (clr[1] && !card_mode_select)
			nxt_state.framing_fault_flag = 1'b0;
		if (clr[0])
			nxt_state.parity_fault_flag = 1'b0;

		if (wr && avs_i.address == CARD_OFS && !te && !re)
			nxt_state.card = (avs_i.writedata[7:0] & CM_WRITABLE) | CM_ONES;
		if (wr && avs_i.address == CTRL_OFS)
			nxt_state.ctrl = avs_i.writedata[7:0];
		if (wr && avs_i.address == TXH_OFS)
			nxt_state.txh = avs_i.writedata[7:0];

		// Transmit side.
		if (tx_take_i && te && !state_ff.transmit_empty_flag && !state_ff.tx_halt)
		begin
			nxt_state.tx_load = 1'b1;
			nxt_state.tx_data = tx_fmt;
			nxt_state.tx_mp = state_ff.multiproc_tx_bit;
			nxt_state.transmit_empty_flag = 1'b1;
		end
		if (!te)
		begin
			nxt_state.transmit_empty_flag = 1'b1;
			nxt_state.transmit_done_flag = 1'b1;
		end
		if (!card_mode_select && tx_last_bit_i && state_ff.transmit_empty_flag)
			nxt_state.transmit_done_flag = 1'b1;
		if (card_mode_select && fire && !state_ff.error_signal_flag && state_ff.transmit_empty_flag)
			nxt_state.transmit_done_flag = 1'b1;

		// Receive side. Only the first stop bit reaches this block.
		if (rx_ok)
		begin
			nxt_state.multiproc_rx_bit = rx_frame_i.mp_bit;
			if (state_ff.receive_full_flag)
				nxt_state.overrun_fault_flag = 1'b1;
			else if (!card_mode_select && !rx_frame_i.stop_bit)
			begin
				nxt_state.framing_fault_flag = 1'b1;
				nxt_state.rxh = rx_fmt;
			end
			else if (!rx_frame_i.parity_ok)
			begin
				nxt_state.parity_fault_flag = 1'b1;
				nxt_state.rxh = rx_fmt;
			end
			else
			begin
				nxt_state.receive_full_flag = 1'b1;
				nxt_state.rxh = rx_fmt;
			end
		end
		if (card_mode_select && err_sample_i && !state_ff.err_s2)
			nxt_state.error_signal_flag = 1'b1;

		nxt_state.rx_halt = nxt_state.overrun_fault_flag || nxt_state.framing_fault_flag || nxt_state.parity_fault_flag;
		nxt_state.tx_halt = !nxt_state.card[CM_CARD_MODE_SELECT]
			&& nxt_state.ctrl[CT_SYNC]
			&& (nxt_state.framing_fault_flag || nxt_state.overrun_fault_flag);
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_ff <= RST_STATE;
		else
			state_ff <= nxt_state;
	end

	// ==========================================================
	// Outputs.
	assign avs_readdata_o = state_ff.rdata;
	assign avs_waitrequest_o = state_ff.waitreq;
	assign tx_load_o = state_ff.tx_load;
	assign tx_data_o = state_ff.tx_data;
	assign tx_mp_bit_o = state_ff.tx_mp;
	assign rx_halt_o = state_ff.rx_halt;
	assign tx_halt_o = state_ff.tx_halt;
	assign smart_card_o = state_ff.card[CM_CARD_MODE_SELECT];
	assign clock_count_sel_o = {state_ff.card[CM_CLOCK_COUNT_TOP_BIT],
		state_ff.ctrl[CT_CLOCK_COUNT_MID_BIT], state_ff.ctrl[CT_CLOCK_COUNT_LOW_BIT]};

	// ==========================================================
	// Assertions.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	property p_fer_set;
		rx_ok && !card_mode_select && !state_ff.receive_full_flag && !rx_frame_i.stop_bit
			|=> state_ff.framing_fault_flag && !state_ff.receive_full_flag && state_ff.rx_halt;
	endproperty
	a_fer_set: assert property (p_fer_set)
		else $error("framing fault not flagged");

	property p_fault_blocks;
		halted && !clr[2] && !clr[1] && !clr[0] ##1 rx_valid_i
			|=> $stable(state_ff.rxh);
	endproperty
	a_fault_blocks: assert property (p_fault_blocks)
		else $error("holding register moved during a fault");

	property p_per_set;
		rx_ok && !state_ff.receive_full_flag && (card_mode_select || rx_frame_i.stop_bit)
			&& !rx_frame_i.parity_ok |=> state_ff.parity_fault_flag && !state_ff.receive_full_flag;
	endproperty
	a_per_set: assert property (p_per_set)
		else $error("parity fault not flagged");

	property p_overrun;
		rx_ok && state_ff.receive_full_flag |=> state_ff.overrun_fault_flag && $stable(state_ff.rxh);
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not handled");

	property p_full_clean;
		rx_ok && !state_ff.receive_full_flag && (card_mode_select || rx_frame_i.stop_bit)
			&& rx_frame_i.parity_ok |=> state_ff.receive_full_flag
			&& state_ff.rxh == $past(rx_fmt);
	endproperty
	a_full_clean: assert property (p_full_clean)
		else $error("clean reception not stored");

	property p_te_off;
		!te |=> state_ff.transmit_empty_flag && state_ff.transmit_done_flag;
	endproperty
	a_te_off: assert property (p_te_off)
		else $error("transmit flags not forced with TE low");

	property p_card_lock;
		wr && avs_i.address == CARD_OFS && (te || re)
			|=> $stable(state_ff.card);
	endproperty
	a_card_lock: assert property (p_card_lock)
		else $error("card register changed while enabled");

	property p_reserved;
		req && state_ff.waitreq && avs_i.address == CARD_OFS
			##1 done |-> avs_readdata_o[6:4] == 3'h7 && avs_readdata_o[1];
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved card bits not read as one");

	property p_no_blind_clear;
		st_wr && !state_ff.arm[3] |=> state_ff.receive_full_flag || !$past(state_ff.receive_full_flag);
	endproperty
	a_no_blind_clear: assert property (p_no_blind_clear)
		else $error("flag cleared without prior read");

	property p_ers_set;
		card_mode_select && err_sample_i && !state_ff.err_s2 |=> state_ff.error_signal_flag;
	endproperty
	a_ers_set: assert property (p_ers_set)
		else $error("error signal not flagged");

	property p_transmit_done_flag_card;
		card_mode_select && fire && !state_ff.error_signal_flag && state_ff.transmit_empty_flag |=> state_ff.transmit_done_flag;
	endproperty
	a_transmit_done_flag_card: assert property (p_transmit_done_flag_card)
		else $error("card transmit done missed");

	c_overrun: cover property (rx_ok && state_ff.receive_full_flag);
	c_fer: cover property (rx_ok && !card_mode_select && !rx_frame_i.stop_bit);
	c_load: cover property (state_ff.tx_load ##[1:64] fire);
	c_clear: cover property (clr[3]);
endmodule
`default_nettype wire

// ==== testbench/far_node_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side: frame arrival, shifter pacing and card error signal.
module far_node_model
	import serial_status_pkg::*;
(
	input  wire logic                   ref_clk_i,
	input  wire logic                   rstn_i,
	output logic                        rx_valid_o,
	output serial_status_pkg::rx_frame_t rx_frame_o,
	output logic                        tx_take_o,
	output logic                        tx_last_bit_o,
	output logic                        half_etu_o,
	output logic                        err_line_o,
	output logic                        err_sample_o
);
	logic [2:0] etu_cnt;

	// A half bit every 8 clocks leaves room for a register read between.
	always_ff @(posedge ref_clk_i or negedge rstn_i)
		if (!rstn_i)
			etu_cnt <= 3'h0;
		else
			etu_cnt <= etu_cnt + 3'h1;
	assign half_etu_o = (etu_cnt == 3'h7);

	initial
	begin
		rx_valid_o = 1'b0;
		rx_frame_o = '0;
		tx_take_o = 1'b0;
		tx_last_bit_o = 1'b0;
		err_line_o = 1'b1;
		err_sample_o = 1'b0;
	end

	// Frame fields go stale by inversion so no old value looks valid.
	task automatic send(input rx_frame_t f);
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b1;
		rx_frame_o <= f;
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b0;
		rx_frame_o <= ~f;
	endtask

	task automatic take();
		@(posedge ref_clk_i);
		tx_take_o <= 1'b1;
		@(posedge ref_clk_i);
		tx_take_o <= 1'b0;
	endtask

	task automatic last_bit();
		@(posedge ref_clk_i);
		tx_last_bit_o <= 1'b1;
		@(posedge ref_clk_i);
		tx_last_bit_o <= 1'b0;
	endtask

	// The line is pulled up; it is held low across the synchroniser.
	task automatic err_signal();
		@(posedge ref_clk_i);
		err_line_o <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		err_sample_o <= 1'b1;
		@(posedge ref_clk_i);
		err_sample_o <= 1'b0;
		err_line_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== testbench/serial_status_card_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_status_card_test;
	import serial_status_pkg::*;
	logic        ref_clk;
	logic        rstn;
	avs_req_t    avs;
	logic [31:0] rdata;
	logic        wreq;
	logic        rx_valid;
	rx_frame_t   rx_frame;
	logic        take;
	logic        last_bit;
	logic        half_etu;
	logic        err_line;
	logic        err_sample;
	logic        tx_load;
	logic [7:0]  tx_data;
	logic        tx_mp;
	logic        rx_halt;
	logic        tx_halt;
	logic [2:0]  ccs;
	logic        card;
	int          n_mismatch;
	int          compares;
	int          cycles;
	int          n;
	logic [7:0]  q;
	logic [7:0]  fl;

	serial_status_card serial_status_card_i (.ref_clk_i(ref_clk),
		.rstn_i(rstn), .avs_i(avs), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .rx_valid_i(rx_valid),
		.rx_frame_i(rx_frame), .tx_take_i(take), .tx_last_bit_i(last_bit),
		.half_etu_i(half_etu), .err_line_i(err_line),
		.err_sample_i(err_sample), .tx_load_o(tx_load), .tx_data_o(tx_data),
		.tx_mp_bit_o(tx_mp), .rx_halt_o(rx_halt), .tx_halt_o(tx_halt),
		.clock_count_sel_o(ccs), .smart_card_o(card));
	far_node_model far_node_model_i (.ref_clk_i(ref_clk), .rstn_i(rstn),
		.rx_valid_o(rx_valid), .rx_frame_o(rx_frame), .tx_take_o(take),
		.tx_last_bit_o(last_bit), .half_etu_o(half_etu),
		.err_line_o(err_line), .err_sample_o(err_sample));

	// ==========================================================
	// Clock, hang guard and verdict.
	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	task automatic print_verdict();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ==========================================================
	// Avalon master and comparisons.
	task automatic bus(input logic [4:0] a, input logic wr,
		input logic [7:0] d);
		@(posedge ref_clk);
		avs.address <= a;
		avs.read <= ~wr;
		avs.write <= wr;
		avs.writedata <= {24'h0, d};
		do @(posedge ref_clk); while (wreq !== 1'b0);
		q = rdata[7:0];
		avs.read <= 1'b0;
		avs.write <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] m,
		input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk(q & m, e);
	endtask

	function automatic logic [7:0] b(input int i);
		return 8'h01 << i;
	endfunction

	task automatic launch(input logic [7:0] d, input logic mp);
		far_node_model_i.take();
		@(posedge ref_clk);
		chk({7'h0, tx_load}, 8'h01);
		chk(tx_data, d);
		chk({7'h0, tx_mp}, {7'h0, mp});
	endtask

	// ==========================================================
	// Test sequence.
	initial
	begin
		avs = '0;
		avs.byteenable = 4'hf;
		rstn = 1'b0;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(STATUS_OFS, 8'hff, ST_RESET);
		rd(CARD_OFS, 8'hff, CM_RESET);
		chk({5'h0, ccs}, 8'h04);
		rd(CTRL_OFS, 8'hff, CT_RESET);
		rd(5'h14, 8'hff, 8'h00);
		bus(CARD_OFS, 1'b1, 8'h00);
		rd(CARD_OFS, 8'hff, CM_ONES);
		chk({5'h0, ccs}, 8'h00);
		bus(CTRL_OFS, 1'b1, 8'h43);
		bus(CARD_OFS, 1'b1, 8'h01);
		rd(CARD_OFS, 8'hff, CM_ONES);
		far_node_model_i.send('{8'h5a, 1'b1, 1'b1, 1'b1});
		rd(STATUS_OFS, 8'h62, b(ST_RECEIVE_FULL_FLAG) | b(ST_MPB));
		far_node_model_i.send('{8'h33, 1'b1, 1'b1, 1'b0});
		rd(STATUS_OFS, 8'h60, 8'h60);
		rd(RXH_OFS, 8'hff, 8'h5a);
		chk({7'h0, rx_halt}, 8'h01);
		bus(STATUS_OFS, 1'b1, 8'hff);
		bus(STATUS_OFS, 1'b1, 8'h00);
		rd(STATUS_OFS, 8'h60, 8'h60);
		bus(STATUS_OFS, 1'b1, 8'hde);
		rd(STATUS_OFS, 8'h60, 8'h40);
		bus(STATUS_OFS, 1'b1, 8'hbe);
		for (int k = 0; k < 2; k++)
		begin
			fl = k ? b(ST_PER) : b(ST_FER);
			far_node_model_i.send('{8'h11 + 8'(k), k[0], ~k[0], 1'b0});
			rd(STATUS_OFS, 8'h58, fl);
			rd(RXH_OFS, 8'hff, 8'h11 + 8'(k));
			far_node_model_i.send('{8'h77, 1'b1, 1'b1, 1'b0});
			rd(RXH_OFS, 8'hff, 8'h11 + 8'(k));
			chk({7'h0, tx_halt}, {7'h0, ~k[0]});
			bus(CTRL_OFS, 1'b1, 8'h41);
			rd(STATUS_OFS, fl, fl);
			bus(STATUS_OFS, 1'b1, ~fl & 8'hfe);
			bus(CTRL_OFS, 1'b1, 8'h43);
		end
		bus(CTRL_OFS, 1'b1, 8'h03);
		bus(TXH_OFS, 1'b1, 8'ha5);
		rd(STATUS_OFS, 8'h84, 8'h84);
		bus(STATUS_OFS, 1'b1, 8'h7f);
		rd(STATUS_OFS, 8'h85, 8'h01);
		launch(8'ha5, 1'b1);
		rd(STATUS_OFS, 8'h84, 8'h80);
		far_node_model_i.last_bit();
		rd(STATUS_OFS, 8'h04, 8'h04);
		bus(CTRL_OFS, 1'b1, 8'h00);
		bus(CARD_OFS, 1'b1, 8'h0d);
		rd(CARD_OFS, 8'hff, 8'h7f);
		chk({7'h0, card}, 8'h01);
		for (int m = 0; m < 4; m++)
		begin
			n = (m == 1) ? 3 : (m == 2) ? 2 : 5;
			bus(CTRL_OFS, 1'b1, (m == 1) ? 8'h09 : (m == 2) ? 8'h05 : 8'h01);
			bus(TXH_OFS, 1'b1, 8'h01);
			rd(STATUS_OFS, 8'h80, 8'h80);
			bus(STATUS_OFS, 1'b1, 8'h7e);
			@(posedge ref_clk iff half_etu);
			launch(8'h7f, 1'b0);
			if (m == 3)
				far_node_model_i.err_signal();
			repeat (n - 1) @(posedge ref_clk iff half_etu);
			rd(STATUS_OFS, 8'h04, 8'h00);
			repeat (2) @(posedge ref_clk iff half_etu);
			rd(STATUS_OFS, 8'h14, (m == 3) ? 8'h10 : 8'h04);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
